// ===== hdl/sfr_defs.vh
/*
 * Constants of the switch fundamental reset sequencer: sequencer states,
 * register offsets, field positions, reset values and timing counts.
 * Assumes inclusion by its bare name from the design files only.
 */
`ifndef SFR_DEFS_VH
`define SFR_DEFS_VH

// sequencer states
`define SFR_ST_IDLE        4'h0
`define SFR_ST_CAPTURE     4'h1
`define SFR_ST_REGINIT     4'h2
`define SFR_ST_UNLOCK      4'h3
`define SFR_ST_PLL         4'h4
`define SFR_ST_MSMB        4'h5
`define SFR_ST_SSMB        4'h6
`define SFR_ST_LINK        4'h7
`define SFR_ST_EECHK       4'h8
`define SFR_ST_EELOAD      4'h9
`define SFR_ST_HOLD        4'hA
`define SFR_ST_LOCK        4'hB
`define SFR_ST_RUN         4'hC

// register byte offsets
`define SFR_OFS_SWITCH_CONTROL_REG      8'h00
`define SFR_OFS_SMBSTS     8'h04
`define SFR_OFS_BOOTSTS    8'h08
`define SFR_OFS_SEQSTS     8'h0C
`define SFR_OFS_PHYLINK    8'h10

// switch_control_reg fields
`define SFR_CTL_UNLOCK_BIT 0
`define SFR_CTL_HOLD_BIT   1
// smb_status_reg fields
`define SFR_SMB_DONE_BIT   0
`define SFR_SMB_ERR_BIT    1
`define SFR_SMB_CODE_LSB   4
`define SFR_SMB_CODE_MSB   7
// eeprom error codes
`define SFR_EEERR_NONE     4'h0
`define SFR_EEERR_READ     4'h1
`define SFR_EEERR_ADDR     4'h2

// eeprom record layout
`define SFR_REC_LAST_BIT   31
`define SFR_REC_ADDR_MSB   23
`define SFR_REC_ADDR_LSB   16
`define SFR_REC_DATA_MSB   15

// ports and switch modes that load from eeprom (one bit per mode)
`define SFR_NPORTS         12
`define SFR_EE_MODE_MASK   16'h00F0

// reset values
`define SFR_RST_WORD       32'h0000_0000

// timing
`define SFR_CLK_KHZ        100000
`define SFR_STACK_REL_MS   20
`define SFR_PORTS_RDY_MS   100
`define SFR_STACK_REL_CYC  (`SFR_STACK_REL_MS * `SFR_CLK_KHZ)
`define SFR_PORTS_RDY_CYC  (`SFR_PORTS_RDY_MS * `SFR_CLK_KHZ)

`endif

// ===== hdl/sfr_sync.v
/*
 * Two-flop synchroniser for a vector of independent pin levels.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`timescale 1ns/1ps
module sfr_sync #(
	parameter W = 1
) (
	pclk,
	presetn,
	din,
	dout
);
	input  wire         pclk;
	input  wire         presetn;
	input  wire [W-1:0] din;
	output reg  [W-1:0] dout;

	reg [W-1:0] meta_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= {W{1'b0}};
			dout   <= {W{1'b0}};
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule // sfr_sync

// ===== hdl/sfr_eeprom_ld.v
/*
 * Serial eeprom loader: fetches records, turns each into a register write,
 * stops on the last record or on the first error.
 * Assumes the eeprom reader runs on pclk and answers ee_req with ee_ack.
 */
`timescale 1ns/1ps
`include "sfr_defs.vh"
module sfr_eeprom_ld (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        start,
	input  wire        abort,
	output reg         ee_req,
	input  wire        ee_ack,
	input  wire [31:0] ee_word,
	input  wire        ee_fail,
	output reg         wr_en,
	output reg  [7:0]  wr_addr,
	output reg  [15:0] wr_data,
	input  wire        wr_err,
	output wire        busy,
	output reg         done,
	output reg         err,
	output reg  [3:0]  err_code
);
	localparam [1:0] LD_IDLE = 2'd0;
	localparam [1:0] LD_FETCH = 2'd1;
	localparam [1:0] LD_WRITE = 2'd2;

	reg [1:0] st_q;
	reg       last_q;

	assign busy = (st_q != LD_IDLE);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q     <= LD_IDLE;
			last_q   <= 1'b0;
			ee_req   <= 1'b0;
			wr_en    <= 1'b0;
			wr_addr  <= 8'h00;
			wr_data  <= 16'h0000;
			done     <= 1'b0;
			err      <= 1'b0;
			err_code <= `SFR_EEERR_NONE;
		end else begin
			done  <= 1'b0;
			err   <= 1'b0;
			wr_en <= 1'b0;
			if (abort) begin
				st_q   <= LD_IDLE;
				ee_req <= 1'b0;
			end else begin
				case (st_q)
				LD_IDLE: begin
					if (start) begin
						st_q   <= LD_FETCH;
						ee_req <= 1'b1;
					end
				end
				LD_FETCH: begin
					if (ee_ack) begin
						ee_req <= 1'b0;
						if (ee_fail) begin
							// a failed read aborts the whole load
							st_q     <= LD_IDLE;
							err      <= 1'b1;
							err_code <= `SFR_EEERR_READ;
						end else begin
							st_q    <= LD_WRITE;
							wr_en   <= 1'b1;
							last_q  <= ee_word[`SFR_REC_LAST_BIT];
							wr_addr <= ee_word[`SFR_REC_ADDR_MSB:`SFR_REC_ADDR_LSB];
							wr_data <= ee_word[`SFR_REC_DATA_MSB:0];
						end
					end
				end
				LD_WRITE: begin
					if (wr_err) begin
						st_q     <= LD_IDLE;
						err      <= 1'b1;
						err_code <= `SFR_EEERR_ADDR;
					end else if (last_q) begin
						st_q <= LD_IDLE;
						done <= 1'b1;
					end else begin
						st_q   <= LD_FETCH;
						ee_req <= 1'b1;
					end
				end
				default: begin
					st_q   <= LD_IDLE;
					ee_req <= 1'b0;
				end
				endcase
			end
		end
	end
endmodule // sfr_eeprom_ld

// ===== hdl/sfr_seq.v
/*
 * Switch fundamental reset sequencer with its APB register file.
 * Assumes pins arrive asynchronously to pclk, the eeprom reader and the
 * port stacks run on pclk, and presetn is the core power-on reset.
 */
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "sfr_defs.vh"
module sfr_seq #(
	parameter [31:0] STACK_REL_CYC = `SFR_STACK_REL_CYC,
	parameter [31:0] PORTS_RDY_CYC = `SFR_PORTS_RDY_CYC
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire [7:0]  paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        global_reset_input_n,
	input  wire        pll_lock,
	input  wire        master_smb_speed_select,
	input  wire [3:0]  master_smb_addr_strap,
	input  wire [1:0]  slave_smb_addr_strap,
	input  wire [3:0]  switch_operating_mode,
	input  wire        reset_hold_strap,
	output reg         pll_start,
	output reg         msmb_speed,
	output reg  [3:0]  msmb_addr,
	output reg         msmb_init,
	output reg         ssmb_reset_n,
	output reg  [1:0]  ssmb_addr,
	output reg         ssmb_init,
	output reg         stack_reset_n,
	output reg         train_start,
	output reg  [11:0] port_retrain,
	output reg         ports_ready,
	output wire        cfg_retry_all,
	output wire        quasi_reset,
	output reg  [3:0]  switch_mode,
	output reg         normal_op,
	output wire        ee_req,
	input  wire        ee_ack,
	input  wire [31:0] ee_word,
	input  wire        ee_fail
);
	////////////////////////////////////////////////////////////////////////
	// register decode, shared by the bus and the eeprom loader
	function reg_hit;
		input [7:0] a;
		begin
			reg_hit = (a == `SFR_OFS_SWITCH_CONTROL_REG) || (a == `SFR_OFS_SMBSTS) ||
				(a == `SFR_OFS_BOOTSTS) || (a == `SFR_OFS_SEQSTS) ||
				(a == `SFR_OFS_PHYLINK);
		end
	endfunction

	function ee_mode;
		input [3:0] m;
		reg   [15:0] sel;
		begin
			sel     = 16'h0001 << m;
			ee_mode = |(sel & `SFR_EE_MODE_MASK);
		end
	endfunction

	// one write port: bus and loader writes are decoded alike
	function reg_wr;
		input       we;
		input [7:0] a;
		input [7:0] ofs;
		begin
			reg_wr = we && (a == ofs);
		end
	endfunction

	// n cycles have passed on the edge that ends cycle n; the timer saturates
	function deadline;
		input [31:0] t;
		input [31:0] lim;
		begin
			deadline = (t >= lim - 32'h1);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	wire [13:0] pins_s;

	sfr_sync #(
		.W (14)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({global_reset_input_n, pll_lock, master_smb_speed_select,
			master_smb_addr_strap, slave_smb_addr_strap,
			switch_operating_mode, reset_hold_strap}),
		.dout    (pins_s)
	);

	wire       gri_n_s  = pins_s[13];
	wire       lock_s   = pins_s[12];
	wire [11:0] strap_s = pins_s[11:0];

	////////////////////////////////////////////////////////////////////////
	// state and registers
	reg  [3:0]  st_q;
	reg  [3:0]  st_d;
	reg  [11:0] strap_q;
	reg  [31:0] timer_q;
	reg         unlock_q;
	reg         hold_q;
	reg         ee_done_q;
	reg         ee_err_q;
	reg  [3:0]  ee_code_q;
	reg         ee_start_q;

	wire        ld_wr_en;
	wire [7:0]  ld_wr_addr;
	wire [15:0] ld_wr_data;
	wire        ld_busy;
	wire        ld_done;
	wire        ld_err;
	wire [3:0]  ld_code;

	// a restart is any time the global reset is seen low, in idle too
	wire restart = !gri_n_s;

	wire [3:0] cap_switch_operating_mode = strap_q[4:1];

	sfr_eeprom_ld u_ld (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (ee_start_q),
		.abort    (restart),
		.ee_req   (ee_req),
		.ee_ack   (ee_ack),
		.ee_word  (ee_word),
		.ee_fail  (ee_fail),
		.wr_en    (ld_wr_en),
		.wr_addr  (ld_wr_addr),
		.wr_data  (ld_wr_data),
		.wr_err   (!reg_hit(ld_wr_addr)),
		.busy     (ld_busy),
		.done     (ld_done),
		.err      (ld_err),
		.err_code (ld_code)
	);

	////////////////////////////////////////////////////////////////////////
	// apb slave; the loader's write owns the register port for its cycle
	wire access  = psel && penable;
	wire bus_wr  = access && pwrite && !ld_wr_en;
	wire any_wr  = bus_wr || ld_wr_en;
	wire [7:0]  wr_a = ld_wr_en ? ld_wr_addr : paddr;
	wire [31:0] wr_d = ld_wr_en ? {16'h0000, ld_wr_data} : pwdata;

	assign pready  = !ld_wr_en;
	assign pslverr = access && !ld_wr_en && !reg_hit(paddr);

	// reloaded through wait states; a loader write in the wait cycle lands on the same edge, so the read still returns the old value
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `SFR_RST_WORD;
		end else if (psel && !(penable && pready)) begin
			case (paddr)
			`SFR_OFS_SWITCH_CONTROL_REG:   prdata <= {30'h0, hold_q, unlock_q};
			`SFR_OFS_SMBSTS:  prdata <= {24'h0, ee_code_q, 2'b00, ee_err_q, ee_done_q};
			`SFR_OFS_BOOTSTS: prdata <= {20'h0, strap_q};
			`SFR_OFS_SEQSTS:  prdata <= {24'h0, ports_ready, normal_op, stack_reset_n,
				lock_s, st_q};
			`SFR_OFS_PHYLINK: prdata <= `SFR_RST_WORD; // retrain bits are pulses
			default:          prdata <= `SFR_RST_WORD;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer
	always @* begin
		st_d = st_q;
		case (st_q)
		`SFR_ST_IDLE:    if (gri_n_s) st_d = `SFR_ST_CAPTURE;
		`SFR_ST_CAPTURE: st_d = `SFR_ST_REGINIT;
		`SFR_ST_REGINIT: st_d = `SFR_ST_UNLOCK;
		`SFR_ST_UNLOCK:  st_d = `SFR_ST_PLL;
		`SFR_ST_PLL:     if (lock_s) st_d = `SFR_ST_MSMB;
		`SFR_ST_MSMB:    st_d = `SFR_ST_SSMB;
		`SFR_ST_SSMB:    st_d = `SFR_ST_LINK;
		`SFR_ST_LINK:    st_d = `SFR_ST_EECHK;
		`SFR_ST_EECHK:   st_d = ee_mode(cap_switch_operating_mode) ? `SFR_ST_EELOAD : `SFR_ST_HOLD;
		`SFR_ST_EELOAD:  if (ld_done || ld_err) st_d = `SFR_ST_HOLD;
		`SFR_ST_HOLD:    if (!hold_q) st_d = `SFR_ST_LOCK;
		`SFR_ST_LOCK:    st_d = `SFR_ST_RUN;
		`SFR_ST_RUN:     st_d = `SFR_ST_RUN;
		default:         st_d = `SFR_ST_IDLE;
		endcase
		if (restart)
			st_d = `SFR_ST_IDLE;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q       <= `SFR_ST_IDLE;
			strap_q    <= 12'h000;
			timer_q    <= 32'h0000_0000;
			ee_start_q <= 1'b0;
		end else begin
			st_q       <= st_d;
			ee_start_q <= (st_q == `SFR_ST_EECHK) && (st_d == `SFR_ST_EELOAD);
			if (st_q == `SFR_ST_CAPTURE)
				strap_q <= strap_s;
			// time since the reset condition cleared, saturating
			if (st_q == `SFR_ST_IDLE)
				timer_q <= 32'h0000_0000;
			else if (timer_q != 32'hFFFF_FFFF)
				timer_q <= timer_q + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control and status bits
	wire init_regs = (st_q == `SFR_ST_REGINIT) || restart;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unlock_q     <= 1'b0;
			hold_q       <= 1'b0;
			ee_done_q    <= 1'b0;
			ee_err_q     <= 1'b0;
			ee_code_q    <= `SFR_EEERR_NONE;
			port_retrain <= 12'h000;
		end else begin
			port_retrain <= 12'h000;
			if (init_regs) begin
				unlock_q  <= 1'b0;
				hold_q    <= restart ? 1'b0 : strap_q[0];
				ee_done_q <= 1'b0;
				ee_err_q  <= 1'b0;
				ee_code_q <= `SFR_EEERR_NONE;
			end else begin
				if (st_q == `SFR_ST_UNLOCK)
					unlock_q <= 1'b1;
				else if (st_q == `SFR_ST_LOCK)
					unlock_q <= 1'b0;
				// software clears reset_hold; a load error in the same cycle wins
				if (ld_err)
					hold_q <= 1'b1;
				else if (reg_wr(any_wr, wr_a, `SFR_OFS_SWITCH_CONTROL_REG))
					hold_q <= hold_q & wr_d[`SFR_CTL_HOLD_BIT];
				if (ld_done)
					ee_done_q <= 1'b1;
				if (ld_err) begin
					ee_err_q  <= 1'b1;
					ee_code_q <= ld_code;
				end
				if (reg_wr(any_wr, wr_a, `SFR_OFS_PHYLINK))
					port_retrain <= wr_d[`SFR_NPORTS-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outward controls
	wire past_pll  = (st_q > `SFR_ST_PLL);
	wire stack_due = (st_q >= `SFR_ST_LINK) ||
		((st_q != `SFR_ST_IDLE) && deadline(timer_q, STACK_REL_CYC));

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_start     <= 1'b0;
			msmb_speed    <= 1'b0;
			msmb_addr     <= 4'h0;
			msmb_init     <= 1'b0;
			ssmb_reset_n  <= 1'b0;
			ssmb_addr     <= 2'b00;
			ssmb_init     <= 1'b0;
			stack_reset_n <= 1'b0;
			train_start   <= 1'b0;
			ports_ready   <= 1'b0;
			switch_mode   <= 4'h0;
			normal_op     <= 1'b0;
		end else if (restart) begin
			pll_start     <= 1'b0;
			msmb_init     <= 1'b0;
			ssmb_reset_n  <= 1'b0;
			ssmb_init     <= 1'b0;
			stack_reset_n <= 1'b0;
			train_start   <= 1'b0;
			ports_ready   <= 1'b0;
			normal_op     <= 1'b0;
		end else begin
			if (st_q == `SFR_ST_PLL)
				pll_start <= 1'b1;
			msmb_init <= (st_q == `SFR_ST_MSMB);
			if (st_q == `SFR_ST_MSMB) begin
				msmb_speed <= strap_q[11];
				msmb_addr  <= strap_q[10:7];
			end
			ssmb_init <= (st_q == `SFR_ST_SSMB);
			if (st_q == `SFR_ST_SSMB) begin
				ssmb_reset_n <= 1'b1;
				ssmb_addr    <= strap_q[6:5];
			end
			// the deadline releases the stacks even if pll lock is late
			train_start <= stack_due && !stack_reset_n;
			if (stack_due)
				stack_reset_n <= 1'b1;
			if (deadline(timer_q, PORTS_RDY_CYC) && (st_q != `SFR_ST_IDLE))
				ports_ready <= 1'b1;
			if (st_q == `SFR_ST_LOCK) begin
				switch_mode <= cap_switch_operating_mode;
				normal_op   <= 1'b1;
			end
		end
	end

	assign cfg_retry_all = ld_busy || (st_q == `SFR_ST_EELOAD);
	// may show for one cycle before a load starts, up to four if the deadline released the stacks; the load then masks it
	assign quasi_reset   = hold_q && stack_reset_n && !cfg_retry_all && past_pll;
endmodule // sfr_seq

// ===== testbench/sfr_seq_chk.sv
/* checker of the reset sequencer port behaviour.
   assumes it is bound into sfr_seq, with one clock pclk and reset presetn. */
`timescale 1ns/1ps
module sfr_seq_chk #(
	parameter [31:0] STACK_REL_CYC = 200,
	parameter [31:0] PORTS_RDY_CYC = 1000
) (
	input logic       pclk,
	input logic       presetn,
	input logic       global_reset_input_n,
	input logic       pll_lock,
	input logic       master_smb_speed_select,
	input logic [3:0] master_smb_addr_strap,
	input logic [1:0] slave_smb_addr_strap,
	input logic       pll_start,
	input logic       msmb_speed,
	input logic [3:0] msmb_addr,
	input logic       msmb_init,
	input logic       ssmb_reset_n,
	input logic [1:0] ssmb_addr,
	input logic       ssmb_init,
	input logic       stack_reset_n,
	input logic       train_start,
	input logic       ports_ready,
	input logic       cfg_retry_all,
	input logic       quasi_reset,
	input logic       normal_op,
	input logic       ee_req,
	input logic       ee_ack,
	input logic       ee_fail
);
	logic [31:0] cyc_q;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////
	// counts from the raw pin; slack of 5 covers the two-flop synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cyc_q <= 32'h0;
		else if (!global_reset_input_n)
			cyc_q <= 32'h0;
		else if (cyc_q != 32'hFFFF_FFFF)
			cyc_q <= cyc_q + 32'h1;
	end
	////////////////////////////////////////////////////////////////////////
	sequence s_msmb;
		msmb_init;
	endsequence
	sequence s_ssmb;
		ssmb_init && ssmb_reset_n && ssmb_addr == slave_smb_addr_strap;
	endsequence
	property p_idle;
		!global_reset_input_n [*6] |-> !(pll_start || stack_reset_n || normal_op || quasi_reset);
	endproperty
	property p_pll;
		s_msmb |-> pll_start && pll_lock;
	endproperty
	property p_mstrap;
		s_msmb |-> msmb_speed == master_smb_speed_select && msmb_addr == master_smb_addr_strap;
	endproperty
	property p_ssmb;
		s_msmb |-> ##[1:3] s_ssmb;
	endproperty
	property p_stack;
		!stack_reset_n |-> cyc_q < STACK_REL_CYC + 32'd5;
	endproperty
	property p_train;
		$rose(stack_reset_n) |-> ##[0:1] train_start;
	endproperty
	property p_ready;
		!ports_ready |-> cyc_q < PORTS_RDY_CYC + 32'd5;
	endproperty
	property p_retry;
		ee_req |-> cfg_retry_all;
	endproperty
	property p_eeerr;
		ee_req && ee_ack && ee_fail |-> ##[1:4] quasi_reset;
	endproperty
	property p_hold;
		quasi_reset |-> ssmb_reset_n && !normal_op;
	endproperty
	property p_norm;
		normal_op |-> !cfg_retry_all && !quasi_reset;
	endproperty
	a_idle: assert property (p_idle)
		else $error("outputs active under global reset");
	a_pll: assert property (p_pll)
		else $error("master smb init before pll lock");
	a_mstrap: assert property (p_mstrap)
		else $error("master smb strap mismatch");
	a_ssmb: assert property (p_ssmb)
		else $error("slave smb init missing or wrong");
	a_stack: assert property (p_stack)
		else $error("stack reset held too long");
	a_train: assert property (p_train)
		else $error("no training start at stack release");
	a_ready: assert property (p_ready)
		else $error("ports not ready in time");
	a_retry: assert property (p_retry)
		else $error("no retry during eeprom load");
	a_eeerr: assert property (p_eeerr)
		else $error("eeprom error did not hold ports");
	a_hold: assert property (p_hold)
		else $error("quasi reset with slave smb down or normal op");
	a_norm: assert property (p_norm)
		else $error("normal op while retrying or held");
endmodule // sfr_seq_chk

bind sfr_seq sfr_seq_chk #(
	.STACK_REL_CYC(STACK_REL_CYC),
	.PORTS_RDY_CYC(PORTS_RDY_CYC)
) i_sfr_seq_chk (.pclk, .presetn, .global_reset_input_n, .pll_lock,
	.master_smb_speed_select, .master_smb_addr_strap, .slave_smb_addr_strap,
	.pll_start, .msmb_speed, .msmb_addr, .msmb_init, .ssmb_reset_n, .ssmb_addr,
	.ssmb_init, .stack_reset_n, .train_start, .ports_ready, .cfg_retry_all,
	.quasi_reset, .normal_op, .ee_req, .ee_ack, .ee_fail);

// ===== testbench/sfr_ee_model.sv
/* serial eeprom reader model: three records writing the retrain register.
   assumes ee_req is held until ee_ack; rst_n also restarts the record index. */
`timescale 1ns/1ps
module sfr_ee_model (
	input  wire         pclk,
	input  wire         rst_n,
	input  wire         ee_req,
	output logic        ee_ack,
	output logic [31:0] ee_word,
	output logic        ee_fail,
	input  wire  [1:0]  fail_kind,
	input  wire  [1:0]  fail_idx,
	input  wire         slow
);
	logic [1:0] idx_q;
	logic [2:0] wait_q;
	always @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			idx_q <= 2'd0;
			wait_q <= 3'd0;
			ee_ack <= 1'b0;
			ee_fail <= 1'b0;
			ee_word <= 32'h5A5A_5A5A;
		end else begin
			ee_ack <= 1'b0;
			ee_fail <= 1'b0;
			// word only valid with ack; otherwise it toggles so nothing stale is taken
			ee_word <= ~ee_word;
			if (ee_req && !ee_ack) begin
				if (slow && wait_q != 3'd5)
					wait_q <= wait_q + 3'd1;
				else begin
					wait_q <= 3'd0;
					ee_ack <= 1'b1;
					idx_q <= idx_q + 2'd1;
					ee_word <= {idx_q == 2'd2, 7'h0,
						(fail_kind == 2'd2 && idx_q == fail_idx) ? 8'h20 : 8'h10,
						4'h0, 12'h0A5 << idx_q};
					ee_fail <= fail_kind == 2'd1 && idx_q == fail_idx;
				end
			end
		end
	end
endmodule // sfr_ee_model

// ===== testbench/switch_fundamental_reset_sequencer_tb_top.sv
/* self-checking bench of the reset sequencer with an eeprom model.
   assumes deadlines scaled to 200 and 1000 cycles, apb master on pclk. */
`timescale 1ns/1ps
module switch_fundamental_reset_sequencer_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, ee_word, seed;
	logic        global_reset_input_n, pll_lock, master_smb_speed_select;
	logic [3:0]  master_smb_addr_strap, switch_operating_mode, msmb_addr, switch_mode;
	logic [1:0]  slave_smb_addr_strap, ssmb_addr, fail_kind, fail_idx;
	logic        reset_hold_strap, pll_start, msmb_speed, msmb_init, ssmb_reset_n;
	logic        ssmb_init, stack_reset_n, train_start, ports_ready, cfg_retry_all;
	logic        quasi_reset, normal_op, ee_req, ee_ack, ee_fail, slow;
	logic [11:0] port_retrain;
	logic [64:0] exp_q[$];
	logic [64:0] e_m;
	logic [11:0] rt_q[$];
	int          num_errors, comparisons;

	sfr_seq #(.STACK_REL_CYC(32'd200), .PORTS_RDY_CYC(32'd1000)) i_sfr_seq (
		.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .global_reset_input_n, .pll_lock, .master_smb_speed_select,
		.master_smb_addr_strap, .slave_smb_addr_strap, .switch_operating_mode,
		.reset_hold_strap, .pll_start, .msmb_speed, .msmb_addr, .msmb_init,
		.ssmb_reset_n, .ssmb_addr, .ssmb_init, .stack_reset_n, .train_start,
		.port_retrain, .ports_ready, .cfg_retry_all, .quasi_reset, .switch_mode,
		.normal_op, .ee_req, .ee_ack, .ee_word, .ee_fail);
	sfr_ee_model i_sfr_ee_model (.pclk, .rst_n(presetn & global_reset_input_n),
		.ee_req, .ee_ack, .ee_word, .ee_fail, .fail_kind, .fail_idx, .slow);

	always #5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], ^(s & 32'h8020_0003)};
	endfunction

	task give_verdict;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, s);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [64:0] e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			exp_q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 50) begin
			num_errors++;
			give_verdict;
		end
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0, {1'b0, m, e});
	endtask

	// quasi_reset shows for a cycle before a load starts, so it must stand two edges
	task wait_done(input logic q);
		int n, k;
		n = 0;
		k = 0;
		while (normal_op !== 1'b1 && k < 2 && n < 3000) begin
			@(posedge pclk);
			n++;
			k = (q && quasi_reset === 1'b1) ? k + 1 : 0;
		end
		if (normal_op !== 1'b1 && k < 2) begin
			num_errors++;
			give_verdict;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// the next run's reset lands on a running switch, so every run but the first is warm
	task run(input logic [3:0] m, input logic h, input logic [1:0] fk, input logic [1:0] fi);
		logic        ee;
		logic [31:0] r;
		ee = m[3:2] == 2'b01;
		seed = lfsr(seed);
		r = seed;
		global_reset_input_n <= 1'b0;
		pll_lock <= 1'b0;
		{master_smb_speed_select, master_smb_addr_strap, slave_smb_addr_strap} <= r[6:0];
		switch_operating_mode <= m;
		reset_hold_strap <= h;
		fail_kind <= fk;
		fail_idx <= fi;
		slow <= r[7];
		for (int i = 0; i < 3; i++)
			if (ee && (fk == 2'd0 || i < fi))
				rt_q.push_back(12'h0A5 << i);
		repeat (6) @(posedge pclk);
		global_reset_input_n <= 1'b1;
		repeat (8 + r[12:8]) @(posedge pclk);
		pll_lock <= 1'b1;
		wait_done(1'b1);
		{master_smb_speed_select, master_smb_addr_strap, slave_smb_addr_strap} <= ~r[6:0];
		rd(8'h08, {20'h0, r[6:0], m, h}, 32'hFFFF_FFFF);
		if (fk != 2'd0)
			rd(8'h04, {24'h0, 2'b0, fk, 4'h2}, 32'hF2);
		else
			rd(8'h04, {31'h0, ee}, 32'hF3);
		if (h || fk != 2'd0) begin
			chk("quasi_reset", 32'h1, {31'h0, quasi_reset});
			rd(8'h00, 32'h3, 32'hFFFF_FFFF);
			apb(1'b1, 8'h00, 32'h0, 65'h0);
			wait_done(1'b0);
		end
		chk("switch_mode", {28'h0, m}, {28'h0, switch_mode});
		rd(8'h00, 32'h0, 32'hFFFF_FFFF);
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
			e_m = exp_q.pop_front();
			chk("prdata", e_m[31:0], prdata & e_m[63:32]);
			chk("pslverr", {31'h0, e_m[64]}, {31'h0, pslverr});
		end
		if (port_retrain !== 12'h000)
			chk("port_retrain", {20'h0, rt_q.pop_front()}, {20'h0, port_retrain});
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = 42'h0;
		{global_reset_input_n, pll_lock, reset_hold_strap, slow} = 4'h0;
		{master_smb_speed_select, master_smb_addr_strap, slave_smb_addr_strap} = 7'h0;
		{switch_operating_mode, fail_kind, fail_idx} = 8'h0;
		seed = 32'hE9D9_5C7C;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		run(4'h4, 1'b0, 2'd0, 2'd0);
		apb(1'b0, 8'h20, 32'h0, {1'b1, 32'hFFFF_FFFF, 32'h0});
		rt_q.push_back(12'h3C0);
		apb(1'b1, 8'h10, 32'h3C0, 65'h0);
		run(4'h0, 1'b1, 2'd0, 2'd0);
		run(4'h5, 1'b0, 2'd1, 2'd1);
		run(4'h6, 1'b0, 2'd2, 2'd2);
		run(4'h7, 1'b1, 2'd0, 2'd0);
		repeat (4) @(posedge pclk);
		chk("retrain_left", 32'h0, rt_q.size());
		// the last run is left alone long enough to reach the ports deadline
		chk("ports_early", 32'h0, {31'h0, ports_ready});
		for (int n = 0; n < 1100 && ports_ready !== 1'b1; n++)
			@(posedge pclk);
		chk("ports_ready", 32'h1, {31'h0, ports_ready});
		give_verdict;
	end
endmodule // switch_fundamental_reset_sequencer_tb_top
